// file: verification/ipl_codec_props.sv
`default_nettype none
`include "ipl_params.svh"
// ----
// Port checks
// ----
module ipl_codec_props (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_power_cycle,
    input wire logic i_tx_start,
    input wire logic [`IPL_BUF_AW-1:0] i_tx_byte_count,
    input wire logic [15:0] i_base_period,
    input wire logic o_rx_packet_ok,
    input wire logic o_rx_packet_bad,
    input wire logic [15:0] o_drive_period,
    input wire logic o_drive_shifted,
    input wire logic o_tx_busy,
    input wire logic o_tx_done,
    input wire logic o_tx_refused
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    logic act_q;
    logic [9:0] run_q;
    logic [2:0] ps_q;
    // Later start bits of a transfer owe nothing to the report
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) act_q <= 1'b0;
        else act_q <= !o_tx_done && (act_q || o_drive_shifted);
    end
    // Power cycles since the drive last changed, seen through a two-stage sync like the design's
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ps_q <= 3'h0;
            run_q <= 10'h000;
        end else begin
            ps_q <= {ps_q[1:0], i_power_cycle};
            run_q <= ($changed(o_drive_shifted) ? 10'h000 : run_q) + 10'(ps_q[1] & ~ps_q[2]);
        end
    end
    property p_period;
        !$past(i_reset)
            |-> o_drive_period == $past(i_base_period) - ($past(o_drive_shifted) ? 16'h0003 : 16'h0000);
    endproperty
    a_period: assert property (p_period) else $error("drive period wrong");
    property p_small;
        o_drive_shifted |=> o_drive_period >= 16'h012a;
    endproperty
    a_small: assert property (p_small) else $error("shift too large");
    property p_after;
        $rose(o_drive_shifted) && !act_q |-> $past(o_rx_packet_ok, 3);
    endproperty
    a_after: assert property (p_after) else $error("send not after packet");
    property p_block;
        $changed(o_drive_shifted) && act_q |-> run_q[7:0] == 8'h00 && run_q[9:8] != 2'h0;
    endproperty
    a_block: assert property (p_block) else $error("block not 256 cycles");
    property p_refuse;
        i_tx_start && (o_tx_busy || i_tx_byte_count == 5'h00 || i_base_period < 16'h012d) |=> o_tx_refused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start not refused");
    property p_accept;
        i_tx_start && !o_tx_busy && i_tx_byte_count != 5'h00 && i_base_period >= 16'h012d
            |=> !o_tx_refused ##[0:1] o_tx_busy;
    endproperty
    a_accept: assert property (p_accept) else $error("start not taken");
    property p_done;
        o_tx_done |-> !o_drive_shifted ##1 !o_tx_done;
    endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_excl;
        !(o_rx_packet_ok && o_rx_packet_bad);
    endproperty
    a_excl: assert property (p_excl) else $error("ok and bad together");
endmodule : ipl_codec_props
bind ipl_codec ipl_codec_props ipl_codec_props_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_power_cycle(i_power_cycle), .i_tx_start(i_tx_start), .i_tx_byte_count(i_tx_byte_count),
    .i_base_period(i_base_period), .o_rx_packet_ok(o_rx_packet_ok), .o_rx_packet_bad(o_rx_packet_bad),
    .o_drive_period(o_drive_period), .o_drive_shifted(o_drive_shifted), .o_tx_busy(o_tx_busy),
    .o_tx_done(o_tx_done), .o_tx_refused(o_tx_refused));
`default_nettype wire

// file: verification/ipl_rx_model.sv
`default_nettype none
// ----
// Power receiver: load modulation out, frequency shifts in
// ----
module ipl_rx_model #(
    parameter int H = 40,
    parameter int HALF = 1024
) (
    input wire logic i_clk,
    input wire logic i_shifted,
    output var logic o_venv,
    output var logic o_ienv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] use_q = 2'h0;
    initial {o_venv, o_ienv} = 2'h0;
    task automatic tog();
        @(posedge i_clk);
        if (use_q[0]) o_venv <= ~o_venv;
        if (use_q[1]) o_ienv <= ~o_ienv;
        repeat (H - 1) @(posedge i_clk);
    endtask : tog
    // A one adds a mid-bit transition
    task automatic bit_out(input logic b);
        tog();
        if (b) tog();
        else repeat (H) @(posedge i_clk);
    endtask : bit_out
    // An unused path holds its level, as an unloaded envelope would
    task automatic send(input logic [1:0] p, input int n, input logic [31:0] d, input logic bad_par);
        logic [7:0] b;
        use_q = p;
        repeat (20) bit_out(1'b1);
        for (int i = 0; i < n; i++) begin
            b = d[8*i+:8];
            bit_out(1'b0);
            for (int k = 0; k < 8; k++) bit_out(b[k]);
            bit_out(~^b ^ (bad_par && i == n - 1));
            bit_out(1'b1);
        end
        // Closing boundary lets the decoder judge the last stop bit
        tog();
        repeat (4 * H) @(posedge i_clk);
    endtask : send
    // Mid-half samples; a toggle is owed at every bit boundary
    task automatic rx_fsk(output logic [10:0] bits, output logic fault);
        logic h1, h2, prev;
        fault = 1'b0;
        prev = 1'b0;
        wait (i_shifted === 1'b1);
        for (int k = 0; k < 11; k++) begin
            repeat (HALF / 2) @(posedge i_clk);
            h1 = i_shifted;
            repeat (HALF) @(posedge i_clk);
            h2 = i_shifted;
            repeat (HALF / 2) @(posedge i_clk);
            if (h1 == prev || (k == 0 && !h2)) fault = 1'b1;
            bits[k] = h1 ^ h2;
            prev = h2;
        end
    endtask : rx_fsk
endmodule : ipl_rx_model
`default_nettype wire

// file: verification/tb.sv
`default_nettype none
// ----
// Codec bench
// ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] path;
        logic [2:0] n;
        logic [23:0] d;
        logic bpar;
        logic bchk;
        logic pc;
    } ipl_row_s;
    localparam int H = 40;
    // First row runs alone on the current path so its score leads
    ipl_row_s rows [4] = '{'{2'h2, 3'h3, 24'h807f01, 1'b0, 1'b0, 1'b1},
        '{2'h3, 3'h2, 24'h005a12, 1'b0, 1'b0, 1'b0}, '{2'h3, 3'h3, 24'h332211, 1'b0, 1'b1, 1'b0},
        '{2'h1, 3'h1, 24'h0000a5, 1'b1, 1'b0, 1'b0}};
    ipl_row_s row;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, wr_en = 1'b0;
    logic [1:0] pc = 2'h0;
    logic [15:0] base = 16'h0190;
    logic [4:0] cnt = 5'h0, rd_addr = 5'h0;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic venv, ienv, ok, bad, path_cur, shifted, busy, done, refused, fault;
    logic [5:0] rx_len;
    logic [15:0] period;
    logic [31:0] pkt;
    logic [10:0] bits;
    int mismatches = 0, checked = 0, n_ok = 0, n_bad = 0, n_done = 0, n_ref = 0, o0, b0;
    always #10 clk = ~clk;
    // Power stage runs at a quarter of the system clock
    always @(posedge clk) pc <= pc + 2'h1;
    always @(posedge clk) begin
        if (ok === 1'b1) n_ok++;
        if (bad === 1'b1) n_bad++;
        if (done === 1'b1) n_done++;
        if (refused === 1'b1) n_ref++;
    end
    ipl_codec #(.ASK_HALF_CYC(H)) ipl_codec_inst (.i_clk_sys(clk), .i_reset(rst),
        .i_voltage_envelope_input(venv), .i_current_envelope_input(ienv), .i_power_cycle(pc[1]),
        .i_base_period(base), .i_tx_start(start), .i_tx_byte_count(cnt), .i_tx_wr_en(wr_en),
        .i_tx_wr_addr(5'h00), .i_tx_wr_data(wr_data), .i_rx_rd_addr(rd_addr), .o_rx_rd_data(rd_data),
        .o_rx_packet_ok(ok), .o_rx_packet_bad(bad), .o_rx_length(rx_len), .o_path_current(path_cur),
        .o_drive_period(period), .o_drive_shifted(shifted), .o_tx_busy(busy), .o_tx_done(done),
        .o_tx_refused(refused));
    ipl_rx_model #(.H(H), .HALF(1024)) ipl_rx_model_inst (.i_clk(clk), .i_shifted(shifted),
        .o_venv(venv), .o_ienv(ienv));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic stop_test();
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic start_tx(input logic [4:0] c);
        @(posedge clk);
        start <= 1'b1;
        cnt <= c;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : start_tx
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        cmp(16'({ok, bad, busy, done, refused, shifted}), 16'h0000);
        cmp(period, 16'h0000);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        cmp(period, base);
        for (int r = 0; r < 4; r++) begin
            row = rows[r];
            pkt = 32'(row.d);
            pkt[8*row.n+:8] = row.d[23:16] ^ row.d[15:8] ^ row.d[7:0] ^ {7'h00, row.bchk};
            o0 = n_ok;
            b0 = n_bad;
            ipl_rx_model_inst.send(row.path, row.n + 1, pkt, row.bpar);
            cmp(16'(n_ok - o0), 16'(!(row.bpar | row.bchk)));
            cmp(16'(n_bad - b0), 16'(row.bpar | row.bchk));
            cmp(16'(path_cur), 16'(row.pc));
            if (!(row.bpar | row.bchk)) begin
                cmp(16'(rx_len), 16'(row.n + 1));
                for (int i = 0; i <= row.n; i++) begin
                    @(posedge clk);
                    rd_addr <= 5'(i);
                    repeat (2) @(posedge clk);
                    @(negedge clk);
                    cmp(16'(rd_data), 16'(pkt[8*i+:8]));
                end
            end
        end
        @(posedge clk);
        wr_en <= 1'b1;
        wr_data <= 8'hc6;
        @(posedge clk);
        wr_en <= 1'b0;
        base <= 16'h012c;
        start_tx(5'h01);
        base <= 16'h0190;
        start_tx(5'h00);
        cmp(16'(n_ref), 16'h0002);
        start_tx(5'h01);
        cmp(16'(busy), 16'h0001);
        start_tx(5'h01);
        cmp(16'(n_ref), 16'h0003);
        ipl_rx_model_inst.send(2'h3, 2, 32'h00000505, 1'b0);
        cmp(16'(shifted), 16'h0000);
        fork
            ipl_rx_model_inst.send(2'h3, 2, 32'h00000303, 1'b0);
            ipl_rx_model_inst.rx_fsk(bits, fault);
        join
        cmp(16'(bits), 16'({1'b1, ~^8'hc6, 8'hc6, 1'b0}));
        cmp(16'(fault), 16'h0000);
        repeat (20) @(posedge clk);
        cmp(16'(n_done), 16'h0001);
        cmp(16'({shifted, busy}), 16'h0000);
        stop_test();
    end
endmodule : tb
`default_nettype wire

// file: verilog/ipl_codec.sv
`default_nettype none

`include "ipl_params.svh"

module ipl_codec
    import ipl_pkg::*;
#(
    parameter int ASK_HALF_CYC = `IPL_ASK_HALF_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_voltage_envelope_input,
    input wire logic i_current_envelope_input,
    input wire logic i_power_cycle,
    input wire logic [15:0] i_base_period,
    input wire logic i_tx_start,
    input wire logic [`IPL_BUF_AW-1:0] i_tx_byte_count,
    input wire logic i_tx_wr_en,
    input wire logic [`IPL_BUF_AW-1:0] i_tx_wr_addr,
    input wire logic [7:0] i_tx_wr_data,
    input wire logic [`IPL_BUF_AW-1:0] i_rx_rd_addr,
    output logic [7:0] o_rx_rd_data,
    output logic o_rx_packet_ok,
    output logic o_rx_packet_bad,
    output logic [5:0] o_rx_length,
    output logic o_path_current,
    output logic [15:0] o_drive_period,
    output logic o_drive_shifted,
    output logic o_tx_busy,
    output logic o_tx_done,
    output logic o_tx_refused
);

    // ----------------------------------------------------------------
    // Interval thresholds, derived from the half-bit time
    // ----------------------------------------------------------------
    localparam logic [15:0] THR_RUNT = 16'(ASK_HALF_CYC / 2);
    localparam logic [15:0] THR_SHORT = 16'((3 * ASK_HALF_CYC) / 2);
    localparam logic [15:0] THR_LONG = 16'((5 * ASK_HALF_CYC) / 2);
    localparam logic [15:0] THR_OVER = 16'((5 * ASK_HALF_CYC) / 2 + 1);

    function automatic ipl_cls_e classify(input logic [15:0] gap);
        if (gap < THR_RUNT) begin
            classify = IPL_CLS_RUNT;
        end else if (gap < THR_SHORT) begin
            classify = IPL_CLS_SHORT;
        end else if (gap <= THR_LONG) begin
            classify = IPL_CLS_LONG;
        end else begin
            classify = IPL_CLS_OVER;
        end
    endfunction : classify

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] v_sync_q;
    logic [2:0] c_sync_q;
    logic [2:0] p_sync_q;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            v_sync_q <= 3'h0;
            c_sync_q <= 3'h0;
            p_sync_q <= 3'h0;
        end else begin
            v_sync_q <= {v_sync_q[1:0], i_voltage_envelope_input};
            c_sync_q <= {c_sync_q[1:0], i_current_envelope_input};
            p_sync_q <= {p_sync_q[1:0], i_power_cycle};
        end
    end

    logic [1:0] env_edge;
    logic power_tick;
    assign env_edge = {c_sync_q[2] ^ c_sync_q[1], v_sync_q[2] ^ v_sync_q[1]};
    assign power_tick = p_sync_q[1] & ~p_sync_q[2];

    // ----------------------------------------------------------------
    // Per-path interval timers and quality scores
    // ----------------------------------------------------------------
    logic [15:0] gap_q [2];
    logic [3:0] score_q [2];

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            for (int p = 0; p < 2; p++) begin
                gap_q[p] <= `IPL_GAP_MAX;
                score_q[p] <= 4'h0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (env_edge[p]) begin
                    gap_q[p] <= `IPL_GAP_ONE;
                    // Only intervals that fit the bit grid count as good signal
                    if (classify(gap_q[p]) == IPL_CLS_SHORT || classify(gap_q[p]) == IPL_CLS_LONG) begin
                        if (score_q[p] != `IPL_SCORE_MAX) score_q[p] <= score_q[p] + 4'h1;
                    end else if (score_q[p] != 4'h0) begin
                        score_q[p] <= score_q[p] - 4'h1;
                    end
                end else if (gap_q[p] != `IPL_GAP_MAX) begin
                    gap_q[p] <= gap_q[p] + `IPL_GAP_ONE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared bit decoder on the selected path
    // ----------------------------------------------------------------
    ipl_rx_e rx_state_q;
    logic sel_q;
    logic half_q;
    logic sel_edge;
    logic sel_timeout;
    ipl_cls_e sel_cls;
    logic bit_valid;
    logic bit_val;
    logic bit_err;

    assign sel_edge = env_edge[sel_q];
    assign sel_cls = classify(gap_q[sel_q]);
    assign sel_timeout = (gap_q[sel_q] == THR_OVER);

    // Path only switches between packets so a packet never mixes sources
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sel_q <= 1'b0;
        end else if (rx_state_q == IPL_RX_HUNT) begin
            sel_q <= (score_q[1] > score_q[0]);
        end
    end

    always_comb begin
        bit_valid = 1'b0;
        bit_val = 1'b0;
        bit_err = 1'b0;
        if (sel_edge) begin
            case (sel_cls)
                IPL_CLS_SHORT: begin
                    if (half_q) begin
                        bit_valid = 1'b1;
                        bit_val = 1'b1;
                    end
                end
                IPL_CLS_LONG: begin
                    // While hunting, a long after a lone short realigns the half-bit phase
                    if (half_q && rx_state_q == IPL_RX_DATA) begin
                        bit_err = 1'b1;
                    end else begin
                        bit_valid = 1'b1;
                    end
                end
                default: begin
                    bit_err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            half_q <= 1'b0;
        end else if (sel_edge && sel_cls == IPL_CLS_SHORT) begin
            half_q <= ~half_q;
        end else if (sel_edge || sel_timeout) begin
            half_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Byte and packet assembly
    // ----------------------------------------------------------------
    logic [3:0] pre_cnt_q;
    logic [3:0] rx_idx_q;
    logic [7:0] rx_sh_q;
    logic [5:0] rx_cnt_q;
    logic [7:0] rx_xor_q;
    logic [7:0] rx_hdr_q;
    logic rxm_we_q;
    logic [`IPL_BUF_AW-1:0] rxm_addr_q;
    logic [7:0] rxm_data_q;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rx_state_q <= IPL_RX_HUNT;
            pre_cnt_q <= 4'h0;
            rx_idx_q <= `IPL_BIT_START;
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 6'h00;
            rx_xor_q <= 8'h00;
            rx_hdr_q <= 8'h00;
            rxm_we_q <= 1'b0;
            rxm_addr_q <= '0;
            rxm_data_q <= 8'h00;
            o_rx_packet_ok <= 1'b0;
            o_rx_packet_bad <= 1'b0;
            o_rx_length <= 6'h00;
        end else begin
            rxm_we_q <= 1'b0;
            o_rx_packet_ok <= 1'b0;
            o_rx_packet_bad <= 1'b0;
            case (rx_state_q)
                IPL_RX_HUNT: begin
                    if (bit_err || sel_timeout) begin
                        pre_cnt_q <= 4'h0;
                    end else if (bit_valid && bit_val) begin
                        if (pre_cnt_q != `IPL_PREAMBLE_MIN) pre_cnt_q <= pre_cnt_q + 4'h1;
                    end else if (bit_valid) begin
                        pre_cnt_q <= 4'h0;
                        // Start bit after enough preamble ones opens the header byte
                        if (pre_cnt_q == `IPL_PREAMBLE_MIN) begin
                            rx_state_q <= IPL_RX_DATA;
                            rx_idx_q <= `IPL_BIT_START + 4'h1;
                            rx_cnt_q <= 6'h00;
                            rx_xor_q <= 8'h00;
                        end
                    end
                end
                IPL_RX_DATA: begin
                    if (sel_timeout) begin
                        rx_state_q <= IPL_RX_HUNT;
                        // Packet ends when the line goes quiet between bytes
                        if (rx_idx_q == `IPL_BIT_START && rx_cnt_q >= `IPL_MIN_PACKET
                            && rx_xor_q == 8'h00) begin
                            o_rx_packet_ok <= 1'b1;
                            o_rx_length <= rx_cnt_q;
                        end else begin
                            o_rx_packet_bad <= 1'b1;
                        end
                    end else if (bit_err) begin
                        rx_state_q <= IPL_RX_HUNT;
                        o_rx_packet_bad <= 1'b1;
                    end else if (bit_valid) begin
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == `IPL_BIT_START) begin
                            if (bit_val || rx_cnt_q == `IPL_BUF_DEPTH) begin
                                rx_state_q <= IPL_RX_HUNT;
                                o_rx_packet_bad <= 1'b1;
                            end
                        end else if (rx_idx_q < `IPL_BIT_PARITY) begin
                            rx_sh_q <= {bit_val, rx_sh_q[7:1]};
                        end else if (rx_idx_q == `IPL_BIT_PARITY) begin
                            if (~^{rx_sh_q, bit_val}) begin
                                rx_state_q <= IPL_RX_HUNT;
                                o_rx_packet_bad <= 1'b1;
                            end
                        end else begin
                            rx_idx_q <= `IPL_BIT_START;
                            if (!bit_val) begin
                                rx_state_q <= IPL_RX_HUNT;
                                o_rx_packet_bad <= 1'b1;
                            end else begin
                                rxm_we_q <= 1'b1;
                                rxm_addr_q <= rx_cnt_q[`IPL_BUF_AW-1:0];
                                rxm_data_q <= rx_sh_q;
                                rx_xor_q <= rx_xor_q ^ rx_sh_q;
                                rx_cnt_q <= rx_cnt_q + 6'h01;
                                if (rx_cnt_q == 6'h00) rx_hdr_q <= rx_sh_q;
                            end
                        end
                    end
                end
                default: begin
                    rx_state_q <= IPL_RX_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_path_current <= 1'b0;
        end else begin
            o_path_current <= sel_q;
        end
    end

    ipl_mem u_rx_mem (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_wr_en(rxm_we_q),
        .i_wr_addr(rxm_addr_q),
        .i_wr_data(rxm_data_q),
        .i_rd_addr(i_rx_rd_addr),
        .o_rd_data(o_rx_rd_data)
    );

    // ----------------------------------------------------------------
    // Frequency-shift transmitter
    // ----------------------------------------------------------------
    ipl_tx_e tx_state_q;
    logic [`IPL_BUF_AW-1:0] tx_idx_q;
    logic [`IPL_BUF_AW-1:0] tx_last_q;
    logic [10:0] tx_frame_q;
    logic [3:0] tx_bit_q;
    logic tx_half_q;
    logic [7:0] tx_cyc_q;
    logic [7:0] txm_data;
    logic cep_seen;

    assign cep_seen = o_rx_packet_ok && rx_hdr_q == `IPL_CEP_HEADER;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tx_state_q <= IPL_TX_IDLE;
            tx_idx_q <= '0;
            tx_last_q <= '0;
            tx_frame_q <= 11'h000;
            tx_bit_q <= `IPL_BIT_START;
            tx_half_q <= 1'b0;
            tx_cyc_q <= 8'h00;
            o_drive_shifted <= 1'b0;
            o_tx_done <= 1'b0;
            o_tx_refused <= 1'b0;
        end else begin
            o_tx_done <= 1'b0;
            o_tx_refused <= 1'b0;
            if (i_tx_start && (tx_state_q != IPL_TX_IDLE || i_tx_byte_count == '0
                || i_base_period < `IPL_MIN_BASE_PERIOD)) begin
                o_tx_refused <= 1'b1;
            end
            case (tx_state_q)
                IPL_TX_IDLE: begin
                    if (i_tx_start && i_tx_byte_count != '0 && i_base_period >= `IPL_MIN_BASE_PERIOD) begin
                        tx_state_q <= IPL_TX_WAIT;
                        tx_idx_q <= '0;
                        tx_last_q <= i_tx_byte_count - 1'b1;
                    end
                end
                IPL_TX_WAIT: begin
                    if (cep_seen) tx_state_q <= IPL_TX_LOAD;
                end
                IPL_TX_LOAD: begin
                    // Buffer read data is registered, so wait one cycle for it
                    tx_state_q <= IPL_TX_FRAME;
                end
                IPL_TX_FRAME: begin
                    tx_frame_q <= {1'b1, ~^txm_data, txm_data, 1'b0};
                    tx_bit_q <= `IPL_BIT_START;
                    tx_half_q <= 1'b0;
                    tx_cyc_q <= 8'h00;
                    o_drive_shifted <= 1'b1;
                    tx_state_q <= IPL_TX_SEND;
                end
                IPL_TX_SEND: begin
                    if (power_tick) begin
                        if (tx_cyc_q != `IPL_FSK_HALF_LAST) begin
                            tx_cyc_q <= tx_cyc_q + 8'h01;
                        end else begin
                            tx_cyc_q <= 8'h00;
                            tx_half_q <= ~tx_half_q;
                            if (!tx_half_q) begin
                                if (tx_bit_q != `IPL_BIT_START && tx_frame_q[tx_bit_q]) begin
                                    o_drive_shifted <= ~o_drive_shifted;
                                end
                            end else if (tx_bit_q == `IPL_BIT_STOP) begin
                                if (tx_idx_q == tx_last_q) begin
                                    tx_state_q <= IPL_TX_IDLE;
                                    o_drive_shifted <= 1'b0;
                                    o_tx_done <= 1'b1;
                                end else begin
                                    tx_idx_q <= tx_idx_q + 1'b1;
                                    tx_state_q <= IPL_TX_LOAD;
                                end
                            end else begin
                                tx_bit_q <= tx_bit_q + 4'h1;
                                // Boundary toggle; a zero then holds for both halves
                                o_drive_shifted <= ~o_drive_shifted;
                            end
                        end
                    end
                end
                default: begin
                    tx_state_q <= IPL_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_drive_period <= 16'h0000;
            o_tx_busy <= 1'b0;
        end else begin
            // Period count feeds the oscillator-timed power stage
            o_drive_period <= o_drive_shifted ? i_base_period - `IPL_SHIFT_COUNTS : i_base_period;
            o_tx_busy <= (tx_state_q != IPL_TX_IDLE);
        end
    end

    ipl_mem u_tx_mem (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_wr_en(i_tx_wr_en),
        .i_wr_addr(i_tx_wr_addr),
        .i_wr_data(i_tx_wr_data),
        .i_rd_addr(tx_idx_q),
        .o_rd_data(txm_data)
    );

endmodule : ipl_codec

`default_nettype wire

// file: verilog/ipl_mem.sv
`default_nettype none

`include "ipl_params.svh"

module ipl_mem (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire logic [`IPL_BUF_AW-1:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [`IPL_BUF_AW-1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);

    logic [7:0] mem [1 << `IPL_BUF_AW];

    // Array carries no reset so it can map onto plain storage
    always_ff @(posedge i_clk_sys) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule : ipl_mem

`default_nettype wire

// file: verilog/ipl_params.svh
`ifndef IPL_PARAMS_SVH
`define IPL_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and receive timing
// ----------------------------------------------------------------
`define IPL_CLK_HZ 50000000
`define IPL_ASK_BIT_HZ 2000
`define IPL_ASK_HALF_CYC (`IPL_CLK_HZ / (2 * `IPL_ASK_BIT_HZ))
`define IPL_GAP_MAX 16'hffff
`define IPL_GAP_ONE 16'h0001
`define IPL_SCORE_MAX 4'hf
`define IPL_PREAMBLE_MIN 4'h4

// ----------------------------------------------------------------
// Byte and packet framing
// ----------------------------------------------------------------
`define IPL_BIT_START 4'h0
`define IPL_BIT_PARITY 4'h9
`define IPL_BIT_STOP 4'ha
`define IPL_BUF_AW 5
`define IPL_BUF_DEPTH 6'h20
`define IPL_MIN_PACKET 6'h02
`define IPL_CEP_HEADER 8'h03

// ----------------------------------------------------------------
// Transmit timing, in oscillator counts and power cycles
// ----------------------------------------------------------------
`define IPL_OSC_KHZ 60000
`define IPL_SHIFT_COUNTS 16'h0003
`define IPL_MIN_BASE_PERIOD 16'h012d
`define IPL_FSK_HALF_LAST 8'hff

`endif

// file: verilog/ipl_pkg.sv
`default_nettype none

package ipl_pkg;

    // Interval class of one envelope transition, Gray ordered by length
    typedef enum logic [1:0] {
        IPL_CLS_RUNT  = 2'h0,
        IPL_CLS_SHORT = 2'h1,
        IPL_CLS_LONG  = 2'h3,
        IPL_CLS_OVER  = 2'h2
    } ipl_cls_e;

    typedef enum logic [0:0] {
        IPL_RX_HUNT = 1'h0,
        IPL_RX_DATA = 1'h1
    } ipl_rx_e;

    typedef enum logic [2:0] {
        IPL_TX_IDLE  = 3'h0,
        IPL_TX_WAIT  = 3'h1,
        IPL_TX_LOAD  = 3'h3,
        IPL_TX_FRAME = 3'h2,
        IPL_TX_SEND  = 3'h6
    } ipl_tx_e;

endpackage : ipl_pkg

`default_nettype wire
